// [pfp_defs.svh]
`ifndef PFP_DEFS_SVH
`define PFP_DEFS_SVH

// Register bus geometry
`define PFP_ADDR_W        4
`define PFP_DATA_W        32

// Register byte addresses
`define PFP_ADDR_CTRL     4'h0
`define PFP_ADDR_STATUS   4'h4
`define PFP_ADDR_TRY      4'h8
`define PFP_ADDR_FUSE     4'hC

// Control register fields and reset value
`define PFP_CTRL_W        2
`define PFP_CTRL_DET_EN   0
`define PFP_CTRL_BLOW_EN  1
`define PFP_CTRL_RST      2'h3

// Status register field positions
`define PFP_ST_STATE_LSB  0
`define PFP_ST_MODE_LSB   3
`define PFP_ST_PARAM_LSB  5
`define PFP_ST_BIT_LSB    8
`define PFP_ST_LOCK_POS   12

// Parameter keys and per-parameter fuse geometry
`define PFP_NUM_PARAM     4
`define PFP_FUSE_W        9
`define PFP_PARAM_MAX     3'h4
`define PFP_BIT_MAX       4'h8
`define PFP_LOCK_BIT      4'h8
`define PFP_MARGIN_IDX    2'h3
`define PFP_SENS_W        7
`define PFP_QVO_W         7

// Highest code reachable by stepping in try mode, per parameter
`define PFP_TRY_MAX_SENS  9'h07F
`define PFP_TRY_MAX_QVO   9'h03F
`define PFP_TRY_MAX_FACT  9'h07F
`define PFP_TRY_MAX_MARG  9'h1FF

// High pulses needed to leave mode selection, minus one
`define PFP_MODE_EXIT_LAST 1'h1

`endif

// [pfp_pkg.sv]
package pfp_pkg;
    // Programming state, Gray coded along the forward path
    typedef enum logic [2:0] {
        PFP_ST_INIT  = 3'h0,
        PFP_ST_MODE  = 3'h1,
        PFP_ST_PARAM = 3'h3,
        PFP_ST_ADDR  = 3'h2,
        PFP_ST_BLOW  = 3'h6
    } pfp_state_e;

    // Mode key as counted by mid-level pulses
    typedef enum logic [1:0] {
        PFP_MODE_NONE = 2'h0,
        PFP_MODE_BLOW = 2'h1,
        PFP_MODE_TRY  = 2'h2,
        PFP_MODE_READ = 2'h3
    } pfp_mode_e;

    // Fuse word of one parameter register, and the whole fuse array
    typedef logic [8:0]      pfp_word_t;
    typedef logic [3:0][8:0] pfp_fuse_t;
endpackage : pfp_pkg

// [pfp_pulse_if.sv]
interface pfp_pulse_if;
    logic midLevelPulse;   // One-cycle event, mid-level pulse ended
    logic highLevelPulse;  // One-cycle event, high-level pulse ended

    // Detector drives the events
    modport det (output midLevelPulse, output highLevelPulse);
    // Sequencer consumes them
    modport seq (input midLevelPulse, input highLevelPulse);
endinterface : pfp_pulse_if

// [pfp_pulse_detect.sv]
`include "pfp_defs.svh"

module pfp_pulse_detect (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    input  wire logic enable,
    input  wire logic pinAboveMid,
    input  wire logic pinAboveHigh,
    pfp_pulse_if.det  pulses
);
    logic inPulse;   // Pin above the mid threshold in the previous cycle
    logic sawHigh;   // High threshold crossed during this pulse

    // level classification
    // Track one pulse from rise to fall, remember its peak class
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            inPulse <= 1'b0;
            sawHigh <= 1'b0;
        end else if (ce) begin
            inPulse <= pinAboveMid;
            if (pinAboveMid && !inPulse) begin
                sawHigh <= pinAboveHigh;
            end else if (pinAboveMid) begin
                sawHigh <= sawHigh | pinAboveHigh;
            end
        end
    end

    // single event per pulse
    // Emit exactly one event on the falling edge of the pulse
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pulses.midLevelPulse  <= 1'b0;
            pulses.highLevelPulse <= 1'b0;
        end else if (ce) begin
            pulses.midLevelPulse  <= enable && inPulse && !pinAboveMid && !sawHigh;
            pulses.highLevelPulse <= enable && inPulse && !pinAboveMid && sawHigh;
        end
    end

    a_pulse_exclusive: assert property (
        @(posedge clk) disable iff (!resetn)
        !(pulses.midLevelPulse && pulses.highLevelPulse))
        else $error("mid and high pulse events at once");
endmodule : pfp_pulse_detect

// [pfp_fsm_top.sv]
`include "pfp_defs.svh"

// Operation
// - Power-up resets logic into Initial state
// - Intact fuse bits read as zero
// - Initial state ignores mid-level pulses
// - One high pulse enters Mode Selection
// - Mid pulses count mode key 1..3
// - Two high pulses latch mode, enter Parameter, or return to Initial with mode key zero
// - Mid pulses count parameter key 1..4
// - One high pulse enters Bit Field Addressing
// - Mid pulses step the addressed bit field
// - Try mode high pulse returns to Parameter
// - Try values held until power cycle or until that parameter is re-addressed in try mode
// - Blow mode leaves addressing only by blow
// - Addressing alone never blows a fuse
// - Blow mode addresses exactly one bit
// - High pulse blows the addressed fuse
// - Lock-all then any blow hits final fuse
// - Sensitivity field seven bits, codes 0..127
// - Read mode shows fuses serially from LSB
module pfp_fsm_top #(
    parameter int NUM_PARAM = `PFP_NUM_PARAM,
    parameter int FUSE_W    = `PFP_FUSE_W
) (
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire logic                       ce,
    input  wire logic                       pinAboveMid,
    input  wire logic                       pinAboveHigh,
    input  wire pfp_pkg::pfp_fuse_t         fuseState,
    input  wire logic                       finalLockFuse,
    input  wire logic [`PFP_ADDR_W-1:0]     regAddr,
    input  wire logic [`PFP_DATA_W-1:0]     regWdata,
    input  wire logic                       regWrite,
    input  wire logic                       regRead,
    output logic [`PFP_DATA_W-1:0]          regRdata,
    output logic [`PFP_SENS_W-1:0]          sensCode,
    output logic [`PFP_QVO_W-1:0]           qvoCode,
    output logic [FUSE_W-1:0]               marginCode,
    output logic                            blowReq,
    output logic [1:0]                      blowParam,
    output logic [3:0]                      blowBit,
    output logic                            blowFinal,
    output logic                            readBit
);
    import pfp_pkg::*;

    pfp_pulse_if pulses ();                 // Pulse events from the detector

    logic [`PFP_CTRL_W-1:0] ctrl;           // Software control bits
    pfp_state_e             state;          // Programming state
    pfp_state_e             next_state;     // Programming state, next
    pfp_mode_e              modeKey;        // Counted mode key
    logic                   highCnt;        // High pulses seen in mode selection
    logic [2:0]             paramKey;       // Counted parameter key, 1..4
    logic [1:0]             paramIdx;       // Zero-based parameter index
    logic [3:0]             bitIdx;         // Addressed bit position
    logic                   midEv;          // Mid-level pulse event
    logic                   highEv;         // High-level pulse event
    logic                   blowOk;         // Fuse blow allowed now
    pfp_word_t              tryVal [NUM_PARAM];  // Try mode values
    pfp_word_t              effVal [NUM_PARAM];  // Fuse value merged with try value
    pfp_word_t              tryMax [NUM_PARAM];  // Try stepping ceilings

    assign midEv    = pulses.midLevelPulse;
    assign highEv   = pulses.highLevelPulse;
    assign paramIdx = 2'(paramKey - 3'h1);
    assign blowOk   = ctrl[`PFP_CTRL_BLOW_EN] && !finalLockFuse;
    assign tryMax[0] = `PFP_TRY_MAX_SENS;
    assign tryMax[1] = `PFP_TRY_MAX_QVO;
    assign tryMax[2] = `PFP_TRY_MAX_FACT;
    assign tryMax[3] = `PFP_TRY_MAX_MARG;

    // Pin level detector, gated by the control register
    pfp_pulse_detect u_detect (
        .clk          (clk),
        .resetn       (resetn),
        .ce           (ce),
        .enable       (ctrl[`PFP_CTRL_DET_EN]),
        .pinAboveMid  (pinAboveMid),
        .pinAboveHigh (pinAboveHigh),
        .pulses       (pulses.det)
    );

    // Next programming state
    always_comb begin
        next_state = state;
        case (state)
            PFP_ST_INIT: begin
                if (highEv) begin
                    next_state = PFP_ST_MODE;
                end
            end
            PFP_ST_MODE: begin
                if (highEv && highCnt == `PFP_MODE_EXIT_LAST) begin
                    next_state = (modeKey == PFP_MODE_NONE) ? PFP_ST_INIT : PFP_ST_PARAM;
                end
            end
            PFP_ST_PARAM: begin
                if (highEv && paramKey != 3'h0) begin
                    next_state = PFP_ST_ADDR;
                end
            end
            // blow mode leaves only by blowing
            PFP_ST_ADDR: begin
                if (highEv && modeKey != PFP_MODE_BLOW) begin
                    next_state = PFP_ST_PARAM;
                end else if (highEv && blowOk) begin
                    next_state = PFP_ST_BLOW;
                end
            end
            // Held until power is cycled
            PFP_ST_BLOW: begin
                next_state = PFP_ST_BLOW;
            end
            default: begin
                next_state = PFP_ST_INIT;
            end
        endcase
    end

    // reset to initial state
    // State register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= PFP_ST_INIT;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // mode key counting
    // Mode key and high pulse count, cleared on entry
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            modeKey <= PFP_MODE_NONE;
            highCnt <= 1'b0;
        end else if (ce) begin
            if (state == PFP_ST_INIT) begin
                modeKey <= PFP_MODE_NONE;
                highCnt <= 1'b0;
            end else if (state == PFP_ST_MODE) begin
                if (highEv) begin
                    highCnt <= ~highCnt;
                end else if (midEv && modeKey != PFP_MODE_READ) begin
                    modeKey <= pfp_mode_e'(2'(modeKey + 2'h1));
                end
            end
        end
    end

    // parameter key counting
    // Parameter key, cleared whenever selection is entered
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            paramKey <= 3'h0;
        end else if (ce) begin
            if (state != PFP_ST_PARAM && next_state == PFP_ST_PARAM) begin
                paramKey <= 3'h0;
            end else if (state == PFP_ST_PARAM && midEv && paramKey != `PFP_PARAM_MAX) begin
                paramKey <= 3'(paramKey + 3'h1);
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bitIdx <= 4'h0;
        end else if (ce) begin
            if (state == PFP_ST_PARAM) begin
                bitIdx <= 4'h0;
            end else if (state == PFP_ST_ADDR && midEv && modeKey != PFP_MODE_TRY
                         && bitIdx != `PFP_BIT_MAX) begin
                bitIdx <= 4'(bitIdx + 4'h1);
            end
        end
    end

    // Try values per parameter, merged with the fuse state
    for (genvar g = 0; g < NUM_PARAM; g++) begin : g_param
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                tryVal[g] <= '0;
            end else if (ce && modeKey == PFP_MODE_TRY && paramIdx == 2'(g)) begin
                // Re-addressing restarts that parameter from zero
                if (state == PFP_ST_PARAM && next_state == PFP_ST_ADDR) begin
                    tryVal[g] <= '0;
                end else if (state == PFP_ST_ADDR && midEv && tryVal[g] != tryMax[g]) begin
                    tryVal[g] <= 9'(tryVal[g] + 9'h001);
                end
            end
        end
        assign effVal[g] = fuseState[g] | tryVal[g];
    end

    // seven-bit sensitivity code
    // Parameter outputs toward the analog trim
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sensCode   <= '0;
            qvoCode    <= '0;
            marginCode <= '0;
        end else if (ce) begin
            sensCode   <= effVal[0][`PFP_SENS_W-1:0];
            qvoCode    <= effVal[1][`PFP_QVO_W-1:0];
            marginCode <= effVal[`PFP_MARGIN_IDX];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            blowReq   <= 1'b0;
            blowParam <= 2'h0;
            blowBit   <= 4'h0;
            blowFinal <= 1'b0;
        end else if (ce) begin
            blowReq <= 1'b0;
            if (state == PFP_ST_ADDR && next_state == PFP_ST_BLOW) begin
                blowReq   <= 1'b1;
                blowParam <= paramIdx;
                blowBit   <= bitIdx;
                blowFinal <= fuseState[`PFP_MARGIN_IDX][`PFP_LOCK_BIT];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            readBit <= 1'b0;
        end else if (ce) begin
            readBit <= (state == PFP_ST_ADDR && modeKey == PFP_MODE_READ)
                       && fuseState[paramIdx][bitIdx];
        end
    end

    // Control register write
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= `PFP_CTRL_RST;
        end else if (ce && regWrite && regAddr == `PFP_ADDR_CTRL) begin
            ctrl <= regWdata[`PFP_CTRL_W-1:0];
        end
    end

    // Register read, data valid the cycle after the strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            regRdata <= '0;
        end else if (ce) begin
            regRdata <= '0;
            if (regRead) begin
                case (regAddr)
                    `PFP_ADDR_CTRL: begin
                        regRdata[`PFP_CTRL_W-1:0] <= ctrl;
                    end
                    `PFP_ADDR_STATUS: begin
                        regRdata[`PFP_ST_STATE_LSB +: 3] <= state;
                        regRdata[`PFP_ST_MODE_LSB +: 2]  <= modeKey;
                        regRdata[`PFP_ST_PARAM_LSB +: 3] <= paramKey;
                        regRdata[`PFP_ST_BIT_LSB +: 4]   <= bitIdx;
                        regRdata[`PFP_ST_LOCK_POS]       <= finalLockFuse;
                    end
                    `PFP_ADDR_TRY: begin
                        regRdata[FUSE_W-1:0] <= tryVal[paramIdx];
                    end
                    `PFP_ADDR_FUSE: begin
                        regRdata[FUSE_W-1:0] <= effVal[paramIdx];
                    end
                    default: begin
                        regRdata <= '0;
                    end
                endcase
            end
        end
    end

    a_init_mid_ignored: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && state == PFP_ST_INIT && midEv && !highEv) |=> (state == PFP_ST_INIT))
        else $error("mid pulse moved the initial state");

    a_init_to_mode: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && state == PFP_ST_INIT && highEv) |=> (state == PFP_ST_MODE && modeKey == PFP_MODE_NONE))
        else $error("high pulse did not enter mode selection");

    a_mode_two_high: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && state == PFP_ST_MODE && highEv && !highCnt) |=> (state == PFP_ST_MODE && highCnt))
        else $error("mode selection left after one high pulse");

    a_param_to_addr: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && state == PFP_ST_PARAM && highEv && paramKey != 3'h0)
        |=> (state == PFP_ST_ADDR && bitIdx == 4'h0))
        else $error("addressing not entered from parameter selection");

    a_try_return: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && state == PFP_ST_ADDR && highEv && modeKey == PFP_MODE_TRY)
        |=> (state == PFP_ST_PARAM && paramKey == 3'h0))
        else $error("try mode did not return to parameter selection");

    a_blow_held: assert property (
        @(posedge clk) disable iff (!resetn)
        (state == PFP_ST_BLOW) |=> (state == PFP_ST_BLOW) [*2])
        else $error("fuse blowing state left without power cycle");

    a_blow_pulse: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && state == PFP_ST_ADDR && highEv && modeKey == PFP_MODE_BLOW && blowOk)
        |=> (blowReq && blowBit == $past(bitIdx) && blowParam == $past(paramIdx)) ##1 !blowReq)
        else $error("blow request missing or wrong bit");

    a_one_bit: assert property (
        @(posedge clk) disable iff (!resetn)
        (bitIdx <= `PFP_BIT_MAX))
        else $error("addressed bit out of range");

    a_bit_step: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && state == PFP_ST_ADDR && midEv && modeKey != PFP_MODE_TRY && bitIdx != `PFP_BIT_MAX)
        |=> (bitIdx == 4'($past(bitIdx) + 4'h1)))
        else $error("bit field did not step by one");

    a_read_serial: assert property (
        @(posedge clk) disable iff (!resetn)
        (ce && state == PFP_ST_ADDR && modeKey == PFP_MODE_READ)
        |=> (readBit == $past(fuseState[paramIdx][bitIdx])))
        else $error("read bit does not match fuse state");

    a_no_blow_addr: assert property (
        @(posedge clk) disable iff (!resetn)
        blowReq |-> (state == PFP_ST_BLOW && $past(state) == PFP_ST_ADDR))
        else $error("fuse blown outside a blow sequence");
endmodule : pfp_fsm_top

// [pfp_prog_model.sv]
// External programmer: drives the two comparator levels of the output pin
module pfp_prog_model (
    input  wire logic clk,
    output logic      pinAboveMid,
    output logic      pinAboveHigh
);
    timeunit 1ns;
    timeprecision 1ns;

    // Pin idles below both thresholds
    initial begin
        pinAboveMid  = 1'b0;
        pinAboveHigh = 1'b0;
    end

    // One pulse of a chosen width, then a quiet gap so the state can settle
    // one pulse one event
    task automatic pulse(input logic isHigh, input int width);
        @(posedge clk);
        pinAboveMid  <= 1'b1;
        pinAboveHigh <= isHigh;
        repeat (width) @(posedge clk);
        pinAboveMid  <= 1'b0;
        pinAboveHigh <= 1'b0;
        // Gap covers the two low cycles and the three-edge settling
        repeat (5) @(posedge clk);
    endtask : pulse
endmodule : pfp_prog_model

// [testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import pfp_pkg::*;

    logic        clk;           // 250 MHz clock
    logic        resetn;        // Power-up reset, active low
    logic        ce;            // Clock enable, high except during one test
    logic        pinAboveMid;   // Mid comparator from programmer
    logic        pinAboveHigh;  // High comparator from programmer
    pfp_fuse_t   fuseState;     // Blown fuse pattern
    logic        finalLockFuse; // Final memory fuse
    logic [3:0]  regAddr;       // Register address
    logic [31:0] regWdata;      // Register write data
    logic        regWrite;      // Write strobe
    logic        regRead;       // Read strobe
    logic [31:0] regRdata;      // Read data
    logic [6:0]  sensCode;      // Sensitivity code
    logic [6:0]  qvoCode;       // Quiescent level code
    logic [8:0]  marginCode;    // Margin and lock code
    logic        blowReq;       // Blow pulse
    logic [1:0]  blowParam;     // Blown parameter index
    logic [3:0]  blowBit;       // Blown bit index
    logic        blowFinal;     // Final fuse request
    logic        readBit;       // Serial fuse read
    logic [31:0] rd;            // Scratch read value
    int          numErrors;     // Mismatch count
    int          testsRun;      // Comparison count
    int          blowCount;     // Blow pulses seen
    int          n;             // Random step count
    int          p;             // Random parameter key
    int          b;             // Random bit index

    // Free-running clock
    always #2 clk = ~clk;

    // Count blow pulses, a long pulse counts once per cycle
    always @(posedge clk) begin
        if (blowReq === 1'b1) begin
            blowCount++;
        end
    end

    pfp_fsm_top u_dut (
        .clk(clk), .resetn(resetn), .ce(ce), .pinAboveMid(pinAboveMid), .pinAboveHigh(pinAboveHigh),
        .fuseState(fuseState), .finalLockFuse(finalLockFuse), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .sensCode(sensCode),
        .qvoCode(qvoCode), .marginCode(marginCode), .blowReq(blowReq), .blowParam(blowParam),
        .blowBit(blowBit), .blowFinal(blowFinal), .readBit(readBit)
    );

    pfp_prog_model u_prog (
        .clk(clk), .pinAboveMid(pinAboveMid), .pinAboveHigh(pinAboveHigh)
    );

    // Expected status word from its fields
    function automatic logic [31:0] st(input logic [2:0] s, input logic [1:0] m, input logic [2:0] pk,
                                       input logic [3:0] bi, input logic l);
        return {19'h0, l, bi, pk, m, s};
    endfunction : st

    // Compare and report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            numErrors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One-cycle register write
    task automatic regWr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : regWr

    // One-cycle register read, data stands in the next cycle
    task automatic regRd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask : regRd

    // Read and compare
    task automatic checkReg(input logic [3:0] a, input logic [31:0] exp);
        regRd(a, rd);
        check(rd, exp);
    endtask : checkReg

    // Pulse trains of random width
    task automatic mids(input int k);
        repeat (k) u_prog.pulse(1'b0, $urandom_range(3, 1));
    endtask : mids

    task automatic highs(input int k);
        repeat (k) u_prog.pulse(1'b1, $urandom_range(3, 1));
    endtask : highs

    // Supply cycle
    task automatic powerCycle();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
    endtask : powerCycle

    task automatic enterMode(input int k);
        highs(1);
        mids(k);
        highs(2);
    endtask : enterMode

    // Verdict and end of run
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", numErrors, testsRun);
        if (numErrors == 0 && testsRun > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog against a hung sequence
    initial begin
        repeat (40000) @(posedge clk);
        numErrors++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        clk = 1'b0; resetn = 1'b0; ce = 1'b1; fuseState = '0; finalLockFuse = 1'b0;
        regAddr = 4'h0; regWdata = 32'h0; regWrite = 1'b0; regRead = 1'b0;
        numErrors = 0; testsRun = 0; blowCount = 0;
        void'($urandom(39536));
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        check(32'({sensCode, qvoCode, marginCode, blowReq, readBit}), 32'h0);
        checkReg(4'h0, 32'h3);
        checkReg(4'h4, st(PFP_ST_INIT, 2'h0, 3'h0, 4'h0, 1'b0));
        // Unmapped place keeps nothing
        regWr(4'h2, 32'hFFFF_FFFF);
        checkReg(4'h2, 32'h0);
        checkReg(4'h0, 32'h3);
        // Detector off: pulses ignored
        regWr(4'h0, 32'h2);
        highs(1);
        checkReg(4'h4, st(PFP_ST_INIT, 2'h0, 3'h0, 4'h0, 1'b0));
        regWr(4'h0, 32'h3);
        mids(3);
        checkReg(4'h4, st(PFP_ST_INIT, 2'h0, 3'h0, 4'h0, 1'b0));
        // Clock enable low: a high pulse leaves no trace
        ce <= 1'b0;
        highs(1);
        ce <= 1'b1;
        checkReg(4'h4, st(PFP_ST_INIT, 2'h0, 3'h0, 4'h0, 1'b0));
        highs(1);
        checkReg(4'h4, st(PFP_ST_MODE, 2'h0, 3'h0, 4'h0, 1'b0));
        // Every mode key, zero falls back to initial, key saturates past three
        for (int k = 0; k <= 4; k++) begin
            powerCycle();
            highs(1);
            mids(k);
            checkReg(4'h4, st(PFP_ST_MODE, (k > 3) ? 2'h3 : 2'(k), 3'h0, 4'h0, 1'b0));
            highs(2);
            checkReg(4'h4, st((k == 0) ? PFP_ST_INIT : PFP_ST_PARAM, (k > 3) ? 2'h3 : 2'(k), 3'h0, 4'h0, 1'b0));
        end
        // Try two parameters in one supply period
        powerCycle();
        enterMode(2);
        mids(1);
        checkReg(4'h4, st(PFP_ST_PARAM, 2'h2, 3'h1, 4'h0, 1'b0));
        highs(1);
        checkReg(4'h4, st(PFP_ST_ADDR, 2'h2, 3'h1, 4'h0, 1'b0));
        n = $urandom_range(20, 1);
        mids(n);
        checkReg(4'h8, 32'(n));
        highs(1);
        checkReg(4'h4, st(PFP_ST_PARAM, 2'h2, 3'h0, 4'h0, 1'b0));
        mids(2);
        highs(1);
        p = $urandom_range(15, 1);
        mids(p);
        check(32'(qvoCode), 32'(p));
        check(32'(sensCode), 32'(n));
        check(32'(marginCode), 32'h0);
        // Sensitivity saturates at its top code
        powerCycle();
        check(32'(sensCode), 32'h0);
        enterMode(2);
        mids(1);
        highs(1);
        mids(130);
        checkReg(4'h8, 32'h7F);
        check(32'(sensCode), 32'h7F);
        // Blow one bit of a user parameter
        powerCycle();
        p = ($urandom_range(2, 0) == 2) ? 4 : $urandom_range(2, 1);
        b = $urandom_range(8, 0);
        enterMode(1);
        mids(p);
        highs(1);
        mids(b);
        checkReg(4'h4, st(PFP_ST_ADDR, 2'h1, 3'(p), 4'(b), 1'b0));
        check(32'(blowCount), 32'h0);
        regWr(4'h0, 32'h1);
        highs(1);
        checkReg(4'h4, st(PFP_ST_ADDR, 2'h1, 3'(p), 4'(b), 1'b0));
        regWr(4'h0, 32'h3);
        highs(1);
        check(32'(blowCount), 32'h1);
        check(32'({blowParam, blowBit, blowFinal}), 32'({2'(p - 1), 4'(b), 1'b0}));
        highs(1);
        checkReg(4'h4, st(PFP_ST_BLOW, 2'h1, 3'(p), 4'(b), 1'b0));
        check(32'(blowCount), 32'h1);
        // power cycle, then lock-all bit alone
        powerCycle();
        enterMode(1);
        mids(4);
        highs(1);
        mids(8);
        highs(1);
        check(32'({blowParam, blowBit, blowFinal}), 32'({2'h3, 4'h8, 1'b0}));
        powerCycle();
        fuseState[3][8] <= 1'b1;
        enterMode(1);
        mids(1);
        highs(1);
        mids(2);
        highs(1);
        check(32'(blowCount), 32'h3);
        check(32'(blowFinal), 32'h1);
        check(32'(marginCode), 32'h100);
        // Final fuse blown: no further blow
        powerCycle();
        finalLockFuse <= 1'b1;
        enterMode(1);
        mids(1);
        highs(1);
        highs(1);
        checkReg(4'h4, st(PFP_ST_ADDR, 2'h1, 3'h1, 4'h0, 1'b1));
        check(32'(blowCount), 32'h3);
        // Serial fuse read, key saturating at four
        powerCycle();
        finalLockFuse <= 1'b0;
        fuseState <= 36'({$urandom(), $urandom()});
        enterMode(3);
        mids(6);
        checkReg(4'h4, st(PFP_ST_PARAM, 2'h3, 3'h4, 4'h0, 1'b0));
        highs(1);
        checkReg(4'hC, 32'(fuseState[3]));
        for (int i = 0; i < 9; i++) begin
            check(32'(readBit), 32'(fuseState[3][i]));
            mids(1);
        end
        report_and_stop();
    end
endmodule : testbench
